// [sadc_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sadc_cfg.svh"
module sadc_top
  import sadc_pkg::*;
(
  input  wire logic        clk_i,          // 10 MHz clock
  input  wire logic        sys_rst_i,      // sync reset, high
  input  wire logic        convert_strobe_i,// convert pin
  input  wire logic        daisy_select_i, // chain mode pin
  input  wire logic        readout_gate_i, // gate or serial in
  input  wire logic        sck_i,          // host serial clock
  input  wire logic [15:0] analog_code_i,  // sampled input level
  output logic             busy_o,         // conversion busy
  output logic             sdo_o,          // serial data out
  output logic             sdo_oe_o,       // serial out enable
  output logic             powered_o,      // core powered
  output logic             acquiring_o,    // acquisition phase
  output logic [15:0]      fifo_code_o,    // logged result head
  output logic             fifo_valid_o,   // log not empty
  input  wire logic        fifo_ready_i    // log pop
);
  // pin synchronisers
  logic [1:0] cnv_s_r, chn_s_r, gate_s_r, sck_s_r;
  logic       cnv_d_r, sck_d_r;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      cnv_s_r  <= 2'h0;
      chn_s_r  <= 2'h0;
      gate_s_r <= 2'h3;
      sck_s_r  <= 2'h0;
      cnv_d_r  <= 1'b0;
      sck_d_r  <= 1'b0;
    end else begin
      cnv_s_r  <= {cnv_s_r[0], convert_strobe_i};
      chn_s_r  <= {chn_s_r[0], daisy_select_i};
      gate_s_r <= {gate_s_r[0], readout_gate_i};
      sck_s_r  <= {sck_s_r[0], sck_i};
      cnv_d_r  <= cnv_s_r[1];
      sck_d_r  <= sck_s_r[1];
    end
  end
  logic cnv_rise, sck_rise, chain, gate;
  assign cnv_rise = cnv_s_r[1] && !cnv_d_r;
  assign sck_rise = sck_s_r[1] && !sck_d_r;
  assign chain    = chn_s_r[1];
  assign gate     = gate_s_r[1];

  // conversion control
  sadc_state_t st_r, st_nxt;
  logic [15:0] hold_r, hold_nxt;
  logic        start, step;
  sadc_result_t res;
  always_comb begin
    st_nxt   = st_r;
    hold_nxt = hold_r;
    start    = 1'b0;
    unique case (st_r)
      SADC_ACQ: begin
        if (cnv_rise) begin
          hold_nxt = analog_code_i;
          start    = 1'b1;
          st_nxt   = SADC_CONV;
        end
      end
      SADC_CONV: begin
        if (res.valid) st_nxt = SADC_DONE;
      end
      SADC_DONE: begin
        st_nxt = SADC_ACQ;
        // edge right after completion still starts
        if (cnv_rise) begin
          hold_nxt = analog_code_i;
          start    = 1'b1;
          st_nxt   = SADC_CONV;
        end
      end
      default: st_nxt = SADC_ACQ;
    endcase
  end
  // internal timing: one bit trial per clock
  always_comb begin
    step = (st_r == SADC_CONV);
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_r   <= SADC_ACQ;
      hold_r <= `SADC_RESULT_RST;
    end else begin
      st_r   <= st_nxt;
      hold_r <= hold_nxt;
    end
  end

  sadc_sar u_sar (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (start),
    .step_i    (step),
    .sample_i  (hold_nxt),
    .busy_o    (),
    .result_o  (res)
  );

  assign busy_o      = (st_r == SADC_CONV);
  assign powered_o   = (st_r == SADC_CONV);
  assign acquiring_o = (st_r != SADC_CONV);

  // output shifter
  logic [15:0] shreg_r, shreg_nxt;
  logic        sdo_r, sdo_nxt;
  always_comb begin
    shreg_nxt = shreg_r;
    sdo_nxt   = sdo_r;
    if (res.valid) begin
      // same conversion result loaded at once
      shreg_nxt = res.code;
      sdo_nxt   = res.code[15];
    end else if (sck_rise && (chain || !gate) && st_r != SADC_CONV) begin
      // shift MSB first per clock rise
      shreg_nxt = {shreg_r[14:0], chain ? gate : 1'b0};
      sdo_nxt   = shreg_r[14];
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      shreg_r <= `SADC_RESULT_RST;
      sdo_r   <= 1'b0;
    end else begin
      shreg_r <= shreg_nxt;
      sdo_r   <= sdo_nxt;
    end
  end
  assign sdo_o    = sdo_r;
  assign sdo_oe_o = chain || !gate;

  // result log of straight binary codes
  sadc_fifo #(
    .WIDTH (`SADC_RES_BITS),
    .DEPTH (`SADC_FIFO_DEPTH)
  ) u_fifo (
    .clk_i      (clk_i),
    .sys_rst_i  (sys_rst_i),
    .wr_data_i  (res.code),
    .wr_valid_i (res.valid),
    .wr_ready_o (),
    .rd_data_o  (fifo_code_o),
    .rd_valid_o (fifo_valid_o),
    .rd_ready_i (fifo_ready_i)
  );
endmodule : sadc_top
`default_nettype wire

// [sadc_cfg.svh]
// Function
// - Mode select low: gate input enables or disables the serial output.
// - Mode select high: gate input becomes serial data from upstream converter.
// - Rising convert strobe powers up the core and starts a conversion.
// - Busy rises at conversion start, falls when conversion finishes.
// - Enabled output shifts result MSB first, one bit per serial clock rise.
// - Result is 16-bit unsigned straight binary over 65536 equal steps.
// - Acquisition and conversion phases alternate; conversion runs successive approximation.
// - No latency: readout data is the result of the conversion just finished.
// - Core powers down automatically between conversions.
// - Normal mode drives output only while gate is low, else releases it.
// - Further convert edges are ignored until the running conversion completes.
// - Internal timer runs each conversion as 16 bit trials, one per clock; busy lasts 17 clocks (1700 ns at 10 MHz).
// - Last result stays readable while powered down.
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH
`define SADC_RES_BITS      16
`define SADC_CLK_MHZ       10
`define SADC_TCONV_MAX_NS  322
`define SADC_TCONV_CYC     ((`SADC_TCONV_MAX_NS * `SADC_CLK_MHZ) / 1000)
`define SADC_BIT_CYC_W     4
`define SADC_FIFO_DEPTH    32
`define SADC_RESULT_RST    16'h0000
`define SADC_MSB_ONEHOT    16'h8000
`define SADC_LSB_ONEHOT    16'h0001
`endif

// [sadc_pkg.sv]
package sadc_pkg;
  typedef enum logic [1:0] {
    SADC_ACQ  = 2'b00,
    SADC_CONV = 2'b01,
    SADC_DONE = 2'b11
  } sadc_state_t;
  typedef struct packed {
    logic        valid;
    logic [15:0] code;
  } sadc_result_t;
endpackage : sadc_pkg

// [sadc_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
module sadc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_i,     // clock
  input  wire logic             sys_rst_i, // sync reset
  input  wire logic [WIDTH-1:0] wr_data_i, // write word
  input  wire logic             wr_valid_i,// write valid
  output logic                  wr_ready_o,// not full
  output logic      [WIDTH-1:0] rd_data_o, // head word
  output logic                  rd_valid_o,// not empty
  input  wire logic             rd_ready_i // pop
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wp_r, wp_nxt, rp_r, rp_nxt;
  logic             wr_en, rd_en;
  assign wr_ready_o = (wp_r - rp_r) != (AW+1)'(DEPTH);
  assign rd_valid_o = wp_r != rp_r;
  assign rd_data_o  = mem_r[rp_r[AW-1:0]];
  assign wr_en      = wr_valid_i && wr_ready_o;
  assign rd_en      = rd_ready_i && rd_valid_o;
  always_comb begin
    wp_nxt = wr_en ? wp_r + 1'b1 : wp_r;
    rp_nxt = rd_en ? rp_r + 1'b1 : rp_r;
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
    if (wr_en) begin
      mem_r[wp_r[AW-1:0]] <= wr_data_i;
    end
  end
endmodule : sadc_fifo
`default_nettype wire

// [sadc_sar.sv]
`timescale 1ns/1ps
`default_nettype none
`include "sadc_cfg.svh"
module sadc_sar
  import sadc_pkg::*;
(
  input  wire logic        clk_i,       // clock
  input  wire logic        sys_rst_i,   // sync reset
  input  wire logic        start_i,     // start pulse
  input  wire logic        step_i,      // bit-trial enable
  input  wire logic [15:0] sample_i,    // held sample
  output logic             busy_o,      // converting
  output sadc_result_t     result_o     // finished code, one-cycle valid
);
  logic [15:0] trial_r, trial_nxt, bit_r, bit_nxt;
  logic        busy_r, busy_nxt;
  sadc_result_t res_r, res_nxt;
  always_comb begin
    trial_nxt = trial_r;
    bit_nxt   = bit_r;
    busy_nxt  = busy_r;
    res_nxt   = '{valid: 1'b0, code: res_r.code};
    if (start_i && !busy_r) begin
      busy_nxt  = 1'b1;
      bit_nxt   = `SADC_MSB_ONEHOT;
      trial_nxt = `SADC_MSB_ONEHOT;
    end else if (busy_r && step_i) begin
      if (trial_r > sample_i) trial_nxt = trial_r & ~bit_r;
      bit_nxt = bit_r >> 1;
      trial_nxt = trial_nxt | (bit_r >> 1);
      if (bit_r == `SADC_LSB_ONEHOT) begin
        busy_nxt = 1'b0;
        res_nxt  = '{valid: 1'b1, code: (trial_r > sample_i) ? trial_r & ~bit_r : trial_r};
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      trial_r <= 16'h0000;
      bit_r   <= 16'h0000;
      busy_r  <= 1'b0;
      res_r   <= '{valid: 1'b0, code: `SADC_RESULT_RST};
    end else begin
      trial_r <= trial_nxt;
      bit_r   <= bit_nxt;
      busy_r  <= busy_nxt;
      res_r   <= res_nxt;
    end
  end
  assign busy_o   = busy_r;
  assign result_o = res_r;
endmodule : sadc_sar
`default_nettype wire

// [sadc_top_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module sadc_top_monitor (
  input wire logic        clk_i,            // clock
  input wire logic        sys_rst_i,        // reset
  input wire logic        convert_strobe_i, // strobe
  input wire logic        daisy_select_i,   // mode
  input wire logic        readout_gate_i,   // gate
  input wire logic        sck_i,            // serial clock
  input wire logic [15:0] analog_code_i,    // level
  input wire logic        busy_o,           // busy
  input wire logic        sdo_o,            // data out
  input wire logic        sdo_oe_o,         // out enable
  input wire logic        powered_o,        // powered
  input wire logic        acquiring_o,      // acquiring
  input wire logic        fifo_valid_o      // log not empty
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  chk_busy_start: assert property (
    !busy_o && $rose(convert_strobe_i) |-> ##[1:4] busy_o) else $error("no busy after strobe");
  chk_busy_len: assert property (
    $rose(busy_o) |-> busy_o[*8] ##1 busy_o[*8] ##[1:3] !busy_o) else $error("busy length");
  chk_oe_off: assert property (
    (!daisy_select_i && readout_gate_i)[*4] |-> !sdo_oe_o) else $error("oe with gate high");
  chk_oe_on: assert property (
    (!daisy_select_i && !readout_gate_i)[*4] |-> sdo_oe_o) else $error("no oe with gate low");
  chk_chain_oe: assert property (
    daisy_select_i[*4] |-> sdo_oe_o) else $error("no oe in chain");
  chk_power_down: assert property (
    (!busy_o)[*2] |-> !powered_o && acquiring_o) else $error("powered while idle");
  chk_sdo_still: assert property (
    (!sck_i && !busy_o)[*6] |=> $stable(sdo_o)) else $error("sdo moved without sck");
  chk_msb_out: assert property (
    $fell(busy_o) |-> sdo_o == analog_code_i[15]) else $error("msb not presented");
  chk_log_write: assert property (
    $fell(busy_o) |-> ##[0:2] fifo_valid_o) else $error("result not logged");
endmodule : sadc_top_monitor
`default_nettype wire

// [sadc_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module sadc_host_model (
  input  wire logic clk_i,  // bench clock
  input  wire logic sdo_i,  // serial out wire
  output var  logic conv_o, // convert strobe
  output var  logic sck_o,  // serial clock
  output var  logic gate_o  // gate or chain data
);
  initial begin
    conv_o = 1'b0;
    sck_o = 1'b0;
    gate_o = 1'b1;
  end
  task automatic convert();
    @(posedge clk_i);
    conv_o <= 1'b1;
    repeat (2) @(posedge clk_i);
    conv_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask : convert
  // msb first, clock still between frames
  task automatic shift(input int n, input logic [31:0] din, output logic [31:0] dout);
    dout = '0;
    @(posedge clk_i);
    for (int i = 0; i < n; i++) begin
      gate_o <= din[31-i];
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      dout = {dout[30:0], sdo_i};
      @(posedge clk_i);
      sck_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      sck_o <= 1'b0;
    end
    gate_o <= 1'b1;
  endtask : shift
endmodule : sadc_host_model
`default_nettype wire

// [tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
  $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
module tb_top;
  logic        clk_i = 1'b0, sys_rst_i = 1'b1, daisy_select_i = 1'b0, fifo_ready_i = 1'b1;
  logic [15:0] analog_code_i = 16'h0000;
  wire logic   conv, sck, gate;
  logic        busy_o, sdo_o, sdo_oe_o, powered_o, acquiring_o, fifo_valid_o;
  logic [15:0] fifo_code_o;
  logic [31:0] dout;
  int          miscompares = 0, checks = 0, cyc = 0;
  always #50 clk_i = ~clk_i;
  sadc_top u_dut (.clk_i, .sys_rst_i, .convert_strobe_i(conv), .daisy_select_i,
    .readout_gate_i(gate), .sck_i(sck), .analog_code_i, .busy_o, .sdo_o, .sdo_oe_o,
    .powered_o, .acquiring_o, .fifo_code_o, .fifo_valid_o, .fifo_ready_i);
  sadc_host_model u_host (.clk_i, .sdo_i(sdo_oe_o ? sdo_o : ~sdo_o), .conv_o(conv),
    .sck_o(sck), .gate_o(gate));
  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude
  task automatic wait_idle();
    for (int i = 0; i < 40 && busy_o !== 1'b0; i++) @(negedge clk_i);
    `CHK(busy_o, 1'b0)
  endtask : wait_idle
  task automatic run_conv(input logic [15:0] code);
    @(posedge clk_i) analog_code_i <= code;
    u_host.convert();
    @(negedge clk_i);
    `CHK(busy_o, 1'b1)
    `CHK(powered_o, 1'b1)
    `CHK(acquiring_o, 1'b0)
    wait_idle();
    `CHK(acquiring_o, 1'b1)
  endtask : run_conv
  task automatic t_normal();
    logic [15:0] codes [3] = '{16'hffff, 16'h0000, 16'h5aa5};
    foreach (codes[i]) begin
      run_conv(codes[i]);
      `CHK(powered_o, 1'b0)
      u_host.shift(16, 32'h0, dout);
      `CHK(dout[15:0], codes[i])
    end
    @(posedge clk_i) analog_code_i <= 16'ha5c3;
    u_host.convert();
    @(posedge clk_i) analog_code_i <= 16'h8001;
    u_host.convert();
    wait_idle();
    u_host.shift(16, 32'h0, dout);
    `CHK(dout[15:0], 16'ha5c3)
    $display("normal readout done");
  endtask : t_normal
  task automatic t_gate();
    run_conv(16'h3c96);
    u_host.shift(16, 32'hffff_ffff, dout);
    `CHK(sdo_oe_o, 1'b0)
    `CHK(dout[15:0], 16'hffff)
    u_host.shift(16, 32'h0, dout);
    `CHK(dout[15:0], 16'h3c96)
    $display("gated readout done");
  endtask : t_gate
  task automatic t_chain();
    @(posedge clk_i) daisy_select_i <= 1'b1;
    run_conv(16'hc3a5);
    u_host.shift(32, 32'h96e1_0000, dout);
    `CHK(dout, 32'hc3a5_96e1)
    `CHK(sdo_oe_o, 1'b1)
    @(posedge clk_i) daisy_select_i <= 1'b0;
    $display("chain readout done");
  endtask : t_chain
  task automatic t_fifo();
    int n;
    n = 0;
    @(posedge clk_i) fifo_ready_i <= 1'b0;
    for (int i = 0; i < 33; i++) run_conv(16'h0100 + 16'(i));
    @(posedge clk_i) fifo_ready_i <= 1'b1;
    repeat (40) begin
      @(negedge clk_i);
      if (fifo_valid_o === 1'b1) begin
        `CHK(fifo_code_o, 16'h0100 + 16'(n))
        n++;
      end
    end
    `CHK(n, 32)
    $display("result log done");
  endtask : t_fifo
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    t_normal();
    t_gate();
    t_chain();
    t_fifo();
    conclude();
  end
endmodule : tb_top
bind sadc_top sadc_top_monitor u_mon (.clk_i, .sys_rst_i, .convert_strobe_i, .daisy_select_i,
  .readout_gate_i, .sck_i, .analog_code_i, .busy_o, .sdo_o, .sdo_oe_o, .powered_o,
  .acquiring_o, .fifo_valid_o);
`default_nettype wire
